// ### rtl/chgtmr_pkg.sv
// Overview of operation
// - precondition limit 40/60/80 min, 11 disables
// - total limit 3/4/5 hours, 11 disables
// - status pin sinks only while actively charging
// - supply below battery: switch to low drain
// - hot or cold thermistor suspends charging
// - leave-range interrupt needs enable and master
// - return-range interrupt needs enable and master
// - live bit: one inside range, zero outside
// - temperature flag set on event, read clears
// - precondition expiry without threshold: time-out fault
// - timer expiry flag gated by enables, read clears
// - thermal regulation stretches timers by current ratio
package chgtmr_pkg;

    // clock and time base
    localparam int CLK_PERIOD_NS   = 10;
    localparam int TICK_PERIOD_NS  = 1_000_000_000;
    localparam int TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;

    // timer limits, counted in seconds of the time base
    localparam int TMR_W       = 16;
    localparam int SEC_PER_MIN = 60;
    localparam int MIN_PER_HR  = 60;
    localparam int PRE_MIN_0   = 40;
    localparam int PRE_MIN_1   = 60;
    localparam int PRE_MIN_2   = 80;
    localparam int TOT_HR_0    = 3;
    localparam int TOT_HR_1    = 4;
    localparam int TOT_HR_2    = 5;
    localparam logic [TMR_W-1:0] PRE_SEC_0 = TMR_W'(PRE_MIN_0 * SEC_PER_MIN);
    localparam logic [TMR_W-1:0] PRE_SEC_1 = TMR_W'(PRE_MIN_1 * SEC_PER_MIN);
    localparam logic [TMR_W-1:0] PRE_SEC_2 = TMR_W'(PRE_MIN_2 * SEC_PER_MIN);
    localparam logic [TMR_W-1:0] TOT_SEC_0 = TMR_W'(TOT_HR_0 * MIN_PER_HR * SEC_PER_MIN);
    localparam logic [TMR_W-1:0] TOT_SEC_1 = TMR_W'(TOT_HR_1 * MIN_PER_HR * SEC_PER_MIN);
    localparam logic [TMR_W-1:0] TOT_SEC_2 = TMR_W'(TOT_HR_2 * MIN_PER_HR * SEC_PER_MIN);
    localparam logic [1:0]       TMR_OFF   = 2'h3;

    // register byte offsets
    localparam logic [7:0] OFF_CTRL    = 8'h00;
    localparam logic [7:0] OFF_STATUS  = 8'h04;
    localparam logic [7:0] OFF_FLAGS   = 8'h08;
    localparam logic [7:0] OFF_INT_ST  = 8'h0c;
    localparam logic [7:0] OFF_INT_MSK = 8'h10;
    localparam logic [7:0] OFF_PRE_CNT = 8'h14;
    localparam logic [7:0] OFF_TOT_CNT = 8'h18;

    // control register layout
    localparam int CTRL_W          = 10;
    localparam int CTRL_PRE_SEL    = 0;
    localparam int CTRL_TOT_SEL    = 2;
    localparam int CTRL_LEAVE_EN   = 4;
    localparam int CTRL_RETURN_EN  = 5;
    localparam int CTRL_TEMP_MEN   = 6;
    localparam int CTRL_PRE_IRQ_EN = 7;
    localparam int CTRL_TOT_IRQ_EN = 8;
    localparam int CTRL_TMR_MEN    = 9;
    localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;

    // status, flag and interrupt bit positions
    localparam int STAT_IN_RANGE  = 0;
    localparam int STAT_TMR_OUT   = 1;
    localparam int STAT_PIN       = 2;
    localparam int STAT_LOW_DRAIN = 3;
    localparam int FLAG_TEMP      = 0;
    localparam int FLAG_TMR       = 1;
    localparam int INT_W          = 2;
    localparam logic [INT_W-1:0] INT_RST = 2'h0;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // charger state as reported by the charge state machine
    typedef enum logic [6:0] {
        CHG_PRECOND  = 7'h01,
        CHG_FAST     = 7'h02,
        CHG_TOPOFF   = 7'h04,
        CHG_EOC      = 7'h08,
        CHG_SUSPEND  = 7'h10,
        CHG_TEMPFLT  = 7'h20,
        CHG_TMOFLT   = 7'h40
    } chgtmr_chg_e;

    typedef enum logic [1:0] {
        RD_IDLE = 2'h1,
        RD_RESP = 2'h2
    } chgtmr_rd_e;

    typedef enum logic [1:0] {
        WR_IDLE = 2'h1,
        WR_RESP = 2'h2
    } chgtmr_wr_e;

endpackage

// ### rtl/chgtmr_timebase.sv
`timescale 1ns/10ps
module chgtmr_timebase
    import chgtmr_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF
)(
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       slow_en,
    input  wire logic [7:0] current_ratio,
    output logic            advance
);
    localparam int CW = (TICK_CYCLES > 2) ? $clog2(TICK_CYCLES) : 1;

    if (TICK_CYCLES < 2) begin : g_chk
        $error("chgtmr_timebase: TICK_CYCLES must be at least 2");
    end

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic [7:0]    acc;
        logic          adv;
    } chgtmr_tb_s;

    chgtmr_tb_s st;
    chgtmr_tb_s next_st;
    logic       tick;
    logic [8:0] sum;

    // the accumulator lets through ratio/256 of the ticks, so time stretches by 256/ratio
    always_comb
    begin
        next_st = st;
        tick    = (st.cnt == CW'(TICK_CYCLES - 1));
        sum     = {1'b0, st.acc} + {1'b0, current_ratio};
        next_st.adv = 1'b0;
        next_st.cnt = tick ? '0 : st.cnt + 1'b1;
        if (tick)
        begin
            if (slow_en)
            begin
                next_st.acc = sum[7:0];
                next_st.adv = sum[8];
            end
            else
            begin
                next_st.adv = 1'b1;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            st <= '0;
        else
            st <= next_st;
    end

    assign advance = st.adv;

    full_rate_a: assert property (@(posedge aclk) disable iff (!aresetn)
        tick && !slow_en |=> advance) else $error("full-rate tick lost");
    stall_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !tick |=> !advance) else $error("advance without tick");
endmodule

// ### rtl/chgtmr_top.sv
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module chgtmr_top
    import chgtmr_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF
)(
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // axi4-lite slave
    input  wire logic [7:0]   s_axi_awaddr,
    input  wire logic         s_axi_awvalid,
    output logic              s_axi_awready,
    input  wire logic [31:0]  s_axi_wdata,
    input  wire logic [3:0]   s_axi_wstrb,
    input  wire logic         s_axi_wvalid,
    output logic              s_axi_wready,
    output logic [1:0]        s_axi_bresp,
    output logic              s_axi_bvalid,
    input  wire logic         s_axi_bready,
    input  wire logic [7:0]   s_axi_araddr,
    input  wire logic         s_axi_arvalid,
    output logic              s_axi_arready,
    output logic [31:0]       s_axi_rdata,
    output logic [1:0]        s_axi_rresp,
    output logic              s_axi_rvalid,
    input  wire logic         s_axi_rready,
    output logic              irq,
    // charger state machine side
    input  chgtmr_chg_e       charger_state,
    input  wire logic         new_cycle,
    input  wire logic         vbat_precond_ok,
    input  wire logic         thermal_reg_active,
    input  wire logic [7:0]   current_ratio,
    output logic              precharge_fault,
    output logic              total_expire,
    output logic              charge_suspend_temp,
    output logic              power_switch_low_drain,
    // pins
    input  wire logic         charger_input_supply,
    input  wire logic         thermistor_sense_hot,
    input  wire logic         thermistor_sense_cold,
    input  wire logic         charge_status_in,
    output logic              charge_status_out_n,
    output logic              charge_status_oe
);
    typedef struct packed {
        chgtmr_rd_e        rd;
        chgtmr_wr_e        wr;
        logic              aw_held;
        logic              w_held;
        logic [7:0]        waddr;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
        logic [1:0]        bresp;
        logic [CTRL_W-1:0] ctrl;
        logic [INT_W-1:0]  int_status;
        logic [INT_W-1:0]  int_mask;
        logic              temp_flag;
        logic              tmr_flag;
        logic              hot_m;
        logic              hot_q;
        logic              cold_m;
        logic              cold_q;
        logic              sup_m;
        logic              sup_q;
        logic              pin_m;
        logic              pin_q;
        logic              in_range;
        logic              suspend_temp;
        logic              low_drain;
        logic [TMR_W-1:0]  pre_cnt;
        logic [TMR_W-1:0]  tot_cnt;
        logic              pre_done;
        logic              tot_done;
        logic              pre_fault;
        logic              tot_exp;
        logic              stat_oe;
    } chgtmr_top_s;

    // in_range and the supply and pin synchronisers leave reset at their idle level,
    // so reset itself raises no leave event and no false low-drain pulse
    localparam chgtmr_top_s ST_RST = '{
        rd: RD_IDLE, wr: WR_IDLE, ctrl: CTRL_RST, int_status: INT_RST,
        int_mask: INT_RST, in_range: 1'b1, sup_m: 1'b1, sup_q: 1'b1,
        pin_m: 1'b1, pin_q: 1'b1, default: '0};

    chgtmr_top_s      st;
    chgtmr_top_s      next_st;
    logic             advance;
    logic             active;
    logic             new_in;
    logic             leave_evt;
    logic             return_evt;
    logic             temp_evt;
    logic             pre_en;
    logic             tot_en;
    logic             pre_evt;
    logic             tot_evt;
    logic             tmr_evt;
    logic             ar_take;
    logic [TMR_W-1:0] pre_lim;
    logic [TMR_W-1:0] tot_lim;
    logic [31:0]      wmask;
    logic [INT_W-1:0] int_clr;

    function automatic logic [TMR_W-1:0] pre_limit(input logic [1:0] sel);
        case (sel)
            2'h0:    pre_limit = PRE_SEC_0;
            2'h1:    pre_limit = PRE_SEC_1;
            2'h2:    pre_limit = PRE_SEC_2;
            default: pre_limit = '0;
        endcase
    endfunction

    function automatic logic [TMR_W-1:0] tot_limit(input logic [1:0] sel);
        case (sel)
            2'h0:    tot_limit = TOT_SEC_0;
            2'h1:    tot_limit = TOT_SEC_1;
            2'h2:    tot_limit = TOT_SEC_2;
            default: tot_limit = '0;
        endcase
    endfunction

    // time base: one advance per second, fewer while thermal regulation cuts current
    chgtmr_timebase #(
        .TICK_CYCLES   (TICK_CYCLES)
    ) u_timebase (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .slow_en       (thermal_reg_active),
        .current_ratio (current_ratio),
        .advance       (advance)
    );

    // handshake outputs straight from the bus state
    assign s_axi_awready = (st.wr == WR_IDLE) && !st.aw_held;
    assign s_axi_wready  = (st.wr == WR_IDLE) && !st.w_held;
    assign s_axi_bvalid  = (st.wr == WR_RESP);
    assign s_axi_bresp   = st.bresp;
    assign s_axi_arready = (st.rd == RD_IDLE);
    assign s_axi_rvalid  = (st.rd == RD_RESP);
    assign s_axi_rdata   = st.rdata;
    assign s_axi_rresp   = st.rresp;
    assign ar_take       = s_axi_arvalid && s_axi_arready;

    // status pin only ever sinks; the level comes from the enable
    assign charge_status_out_n    = 1'b0;
    assign charge_status_oe       = st.stat_oe;
    assign charge_suspend_temp    = st.suspend_temp;
    assign power_switch_low_drain = st.low_drain;
    assign precharge_fault        = st.pre_fault;
    assign total_expire           = st.tot_exp;
    assign irq                    = |(st.int_status & st.int_mask);

    // event decode from the synchronised comparators and the timers
    always_comb
    begin
        active = (charger_state == CHG_PRECOND) || (charger_state == CHG_FAST)
              || (charger_state == CHG_TOPOFF);
        new_in     = !(st.hot_q || st.cold_q);
        leave_evt  = st.in_range && !new_in;
        return_evt = !st.in_range && new_in;
        temp_evt   = st.ctrl[CTRL_TEMP_MEN]
                  && ((leave_evt && st.ctrl[CTRL_LEAVE_EN])
                   || (return_evt && st.ctrl[CTRL_RETURN_EN]));
        pre_lim = pre_limit(st.ctrl[CTRL_PRE_SEL +: 2]);
        tot_lim = tot_limit(st.ctrl[CTRL_TOT_SEL +: 2]);
        pre_en  = (st.ctrl[CTRL_PRE_SEL +: 2] != TMR_OFF);
        tot_en  = (st.ctrl[CTRL_TOT_SEL +: 2] != TMR_OFF);
        pre_evt = !new_cycle && pre_en && !st.pre_done && (st.pre_cnt >= pre_lim);
        tot_evt = !new_cycle && tot_en && !st.tot_done && (st.tot_cnt >= tot_lim);
        tmr_evt = st.ctrl[CTRL_TMR_MEN]
               && ((pre_evt && st.ctrl[CTRL_PRE_IRQ_EN])
                || (tot_evt && st.ctrl[CTRL_TOT_IRQ_EN]));
        wmask = {{8{st.wstrb[3]}}, {8{st.wstrb[2]}}, {8{st.wstrb[1]}}, {8{st.wstrb[0]}}};
    end

    // next state: bus slave, synchronisers, timers and flags
    always_comb
    begin
        next_st = st;
        int_clr = '0;

        // two-flop synchronisers; only the second stage feeds logic
        next_st.hot_m  = thermistor_sense_hot;
        next_st.hot_q  = st.hot_m;
        next_st.cold_m = thermistor_sense_cold;
        next_st.cold_q = st.cold_m;
        next_st.sup_m  = charger_input_supply;
        next_st.sup_q  = st.sup_m;
        next_st.pin_m  = charge_status_in;
        next_st.pin_q  = st.pin_m;

        next_st.in_range     = new_in;
        next_st.suspend_temp = !new_in;
        next_st.low_drain    = !st.sup_q;
        next_st.stat_oe      = active;

        // write channel: address and data may arrive in either order
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_st.aw_held = 1'b1;
            next_st.waddr   = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_st.w_held = 1'b1;
            next_st.wdata  = s_axi_wdata;
            next_st.wstrb  = s_axi_wstrb;
        end
        case (st.wr)
            WR_IDLE:
            begin
                if (st.aw_held && st.w_held)
                begin
                    next_st.wr    = WR_RESP;
                    next_st.bresp = RESP_OKAY;
                    if (st.waddr == OFF_CTRL)
                        next_st.ctrl = (st.ctrl & ~wmask[CTRL_W-1:0])
                                     | (st.wdata[CTRL_W-1:0] & wmask[CTRL_W-1:0]);
                    else if (st.waddr == OFF_INT_ST)
                        int_clr = st.wdata[INT_W-1:0] & wmask[INT_W-1:0];
                    else if (st.waddr == OFF_INT_MSK)
                        next_st.int_mask = (st.int_mask & ~wmask[INT_W-1:0])
                                         | (st.wdata[INT_W-1:0] & wmask[INT_W-1:0]);
                    else if (st.waddr == OFF_STATUS || st.waddr == OFF_FLAGS
                          || st.waddr == OFF_PRE_CNT || st.waddr == OFF_TOT_CNT)
                        next_st.bresp = RESP_OKAY;
                    else
                        next_st.bresp = RESP_SLVERR;
                end
            end
            WR_RESP:
            begin
                if (s_axi_bready)
                begin
                    next_st.wr      = WR_IDLE;
                    next_st.aw_held = 1'b0;
                    next_st.w_held  = 1'b0;
                end
            end
            default:
                next_st.wr = WR_IDLE;
        endcase

        // read channel; reading the flags clears them, a same-cycle event still sets
        case (st.rd)
            RD_IDLE:
            begin
                if (ar_take)
                begin
                    next_st.rd    = RD_RESP;
                    next_st.rresp = RESP_OKAY;
                    next_st.rdata = '0;
                    if (s_axi_araddr == OFF_CTRL)
                        next_st.rdata = 32'(st.ctrl);
                    else if (s_axi_araddr == OFF_STATUS)
                    begin
                        next_st.rdata[STAT_IN_RANGE]  = st.in_range;
                        next_st.rdata[STAT_TMR_OUT]   = st.pre_done || st.tot_done;
                        next_st.rdata[STAT_PIN]       = st.pin_q;
                        next_st.rdata[STAT_LOW_DRAIN] = st.low_drain;
                    end
                    else if (s_axi_araddr == OFF_FLAGS)
                    begin
                        next_st.rdata[FLAG_TEMP] = st.temp_flag;
                        next_st.rdata[FLAG_TMR]  = st.tmr_flag;
                        next_st.temp_flag        = 1'b0;
                        next_st.tmr_flag         = 1'b0;
                    end
                    else if (s_axi_araddr == OFF_INT_ST)
                        next_st.rdata = 32'(st.int_status);
                    else if (s_axi_araddr == OFF_INT_MSK)
                        next_st.rdata = 32'(st.int_mask);
                    else if (s_axi_araddr == OFF_PRE_CNT)
                        next_st.rdata = 32'(st.pre_cnt);
                    else if (s_axi_araddr == OFF_TOT_CNT)
                        next_st.rdata = 32'(st.tot_cnt);
                    else
                        next_st.rresp = RESP_SLVERR;
                end
            end
            RD_RESP:
            begin
                if (s_axi_rready)
                    next_st.rd = RD_IDLE;
            end
            default:
                next_st.rd = RD_IDLE;
        endcase

        // safety timers; a new cycle wins over counting
        if (new_cycle)
        begin
            next_st.pre_cnt  = '0;
            next_st.tot_cnt  = '0;
            next_st.pre_done = 1'b0;
            next_st.tot_done = 1'b0;
        end
        else
        begin
            if (advance && charger_state == CHG_PRECOND && pre_en && !st.pre_done)
                next_st.pre_cnt = st.pre_cnt + 1'b1;
            if (advance && active && tot_en && !st.tot_done)
                next_st.tot_cnt = st.tot_cnt + 1'b1;
            if (pre_evt)
                next_st.pre_done = 1'b1;
            if (tot_evt)
                next_st.tot_done = 1'b1;
        end
        next_st.pre_fault = pre_evt && (charger_state == CHG_PRECOND) && !vbat_precond_ok;
        next_st.tot_exp   = tot_evt;

        // set after clear: an event in the clearing cycle is kept
        if (temp_evt)
            next_st.temp_flag = 1'b1;
        if (tmr_evt)
            next_st.tmr_flag = 1'b1;
        next_st.int_status = (st.int_status & ~int_clr) | {tmr_evt, temp_evt};
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            st <= ST_RST;
        else
            st <= next_st;
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    pre_limit_a: assert property ($rose(st.pre_done) |-> st.pre_cnt == $past(pre_lim)
        && $past(st.ctrl[CTRL_PRE_SEL +: 2]) != TMR_OFF)
        else $error("precondition timer expired at wrong count");
    tot_limit_a: assert property ($rose(st.tot_done) |-> st.tot_cnt == $past(tot_lim)
        && $past(st.ctrl[CTRL_TOT_SEL +: 2]) != TMR_OFF)
        else $error("total timer expired at wrong count");
    status_drive_a: assert property (charge_status_oe == $past(active)
        && !charge_status_out_n)
        else $error("status pin drive does not follow charger state");
    low_drain_a: assert property ($past(!charger_input_supply, 3) |-> power_switch_low_drain)
        else $error("low-drain switch not applied");
    temp_suspend_a: assert property ($past(thermistor_sense_hot || thermistor_sense_cold, 3)
        |-> charge_suspend_temp)
        else $error("charging not suspended on temperature fault");
    leave_irq_a: assert property ($fell(st.in_range) && $past(st.ctrl[CTRL_LEAVE_EN])
        && $past(st.ctrl[CTRL_TEMP_MEN]) |-> st.temp_flag && st.int_status[0])
        else $error("leave-range interrupt missing");
    return_irq_a: assert property ($rose(st.in_range) && $past(st.ctrl[CTRL_RETURN_EN])
        && $past(st.ctrl[CTRL_TEMP_MEN]) |-> st.temp_flag)
        else $error("return-range interrupt missing");
    in_range_a: assert property (st.in_range == !charge_suspend_temp)
        else $error("live temperature bit disagrees with suspend");
    flag_clear_a: assert property (ar_take && s_axi_araddr == OFF_FLAGS && !temp_evt
        |=> !st.temp_flag ##1 (!st.temp_flag || $past(temp_evt)))
        else $error("temperature flag not cleared by read");
    pre_fault_a: assert property (pre_evt && charger_state == CHG_PRECOND && !vbat_precond_ok
        |=> precharge_fault ##1 !precharge_fault)
        else $error("precondition fault not raised");
    timer_irq_a: assert property (tmr_evt |=> st.tmr_flag && st.int_status[1])
        else $error("timer interrupt flag not set");
    restart_a: assert property (new_cycle |=> st.pre_cnt == '0 && st.tot_cnt == '0
        && !st.pre_done && !st.tot_done)
        else $error("timers not restarted on new cycle");
    stretch_a: assert property (!advance |=> st.pre_cnt == $past(st.pre_cnt)
        || $past(new_cycle))
        else $error("timer moved without time base advance");

    leave_irq_c: cover property (leave_evt && temp_evt ##[1:20] irq);
    pre_fault_c: cover property (precharge_fault);
    tot_exp_c: cover property (total_expire);
    flag_read_c: cover property (ar_take && s_axi_araddr == OFF_FLAGS && st.temp_flag);
endmodule

// ### verif/chgtmr_batt_model.sv
`timescale 1ns/10ps
module chgtmr_batt_model
(
    input  wire logic [1:0] temp_zone,
    input  wire logic       charge_status_out_n,
    input  wire logic       charge_status_oe,
    output logic            thermistor_sense_hot,
    output logic            thermistor_sense_cold,
    output logic            charge_status_in
);
    // pack comparators: zone 1 is hot, zone 2 is cold
    assign thermistor_sense_hot  = (temp_zone == 2'h1);
    assign thermistor_sense_cold = (temp_zone == 2'h2);
    // led pull-up wins whenever the sink lets go
    assign charge_status_in = charge_status_oe ? charge_status_out_n : 1'b1;
endmodule

// ### verif/tb_top.sv
`timescale 1ns/10ps
`define CK(a,b) begin total_checks++; if ((a) !== (b)) begin fails++; \
$display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top
    import chgtmr_pkg::*;
;
    logic        aclk, aresetn, irq, new_cycle, vbat_precond_ok, thermal_reg_active;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, current_ratio;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_val;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, temp_zone;
    logic        precharge_fault, total_expire, charge_suspend_temp, power_switch_low_drain;
    logic        charger_input_supply, thermistor_sense_hot, thermistor_sense_cold;
    logic        charge_status_in, charge_status_out_n, charge_status_oe;
    chgtmr_chg_e charger_state;
    int          fails, total_checks, n;

    // short tick keeps the 40 minute limit at 9600 cycles
    chgtmr_top #(.TICK_CYCLES(4)) u_chgtmr_top (.*);
    chgtmr_batt_model u_chgtmr_batt_model (.*);

    // 100 mhz clock
    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    task tk(input int c);
        repeat (c) @(posedge aclk);
    endtask

    // write: address and data offered together, each released once taken
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask

    // read: data taken at the edge where rvalid is seen
    task rd(input logic [7:0] a, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid);
        rd_val = s_axi_rdata;
        s_axi_rready <= 1'b0;
        `CK(s_axi_rresp, er)
    endtask

    // wait for either expiry pulse, counting cycles into n
    task wait_exp;
        n = 0;
        while (!(precharge_fault || total_expire) && n < 50000)
        begin
            @(posedge aclk);
            n++;
        end
    endtask

    task pulse_new_cycle;
        @(posedge aclk);
        new_cycle <= 1'b1;
        @(posedge aclk);
        new_cycle <= 1'b0;
    endtask

    task t_regs;
        rd(OFF_CTRL, RESP_OKAY);
        `CK(rd_val[9:0], CTRL_RST)
        rd(OFF_STATUS, RESP_OKAY);
        `CK(rd_val[STAT_IN_RANGE], 1'b1)
        rd(8'h40, RESP_SLVERR);
        `CK(rd_val, 32'h0)
        $display("test regs done");
    endtask

    // every charger state, pin level seen through the pull-up
    task t_pin;
        for (int i = 0; i < 7; i++)
        begin
            charger_state <= chgtmr_chg_e'(7'h01 << i);
            tk(3);
            `CK(charge_status_in, (i > 2))
        end
        $display("test pin done");
    endtask

    task t_temp;
        wr(OFF_CTRL, 32'h70);
        wr(OFF_INT_MSK, 32'h1);
        temp_zone <= 2'h1;
        tk(6);
        `CK(charge_suspend_temp, 1'b1)
        `CK(irq, 1'b1)
        rd(OFF_STATUS, RESP_OKAY);
        `CK(rd_val[STAT_IN_RANGE], 1'b0)
        rd(OFF_FLAGS, RESP_OKAY);
        `CK(rd_val[FLAG_TEMP], 1'b1)
        rd(OFF_FLAGS, RESP_OKAY);
        `CK(rd_val[FLAG_TEMP], 1'b0)
        wr(OFF_INT_ST, 32'h1);
        tk(2);
        `CK(irq, 1'b0)
        temp_zone <= 2'h2;
        tk(6);
        `CK(charge_suspend_temp, 1'b1)
        temp_zone <= 2'h0;
        tk(6);
        `CK(charge_suspend_temp, 1'b0)
        `CK(irq, 1'b1)
        rd(OFF_FLAGS, RESP_OKAY);
        `CK(rd_val[FLAG_TEMP], 1'b1)
        wr(OFF_INT_ST, 32'h1);
        // master off: a leave event must not flag
        wr(OFF_CTRL, 32'h30);
        temp_zone <= 2'h1;
        tk(6);
        rd(OFF_FLAGS, RESP_OKAY);
        `CK(rd_val[FLAG_TEMP], 1'b0)
        temp_zone <= 2'h0;
        $display("test temp done");
    endtask

    task t_drain;
        charger_input_supply <= 1'b0;
        tk(5);
        `CK(power_switch_low_drain, 1'b1)
        charger_input_supply <= 1'b1;
        tk(5);
        `CK(power_switch_low_drain, 1'b0)
        $display("test drain done");
    endtask

    // 40 minute limit with battery low, then the disabled setting
    task t_pre;
        wr(OFF_CTRL, 32'h280);
        charger_state <= CHG_PRECOND;
        pulse_new_cycle;
        wait_exp;
        `CK((n > 4 * PRE_SEC_0 - 5) && (n < 4 * PRE_SEC_0 + 9), 1'b1)
        `CK(precharge_fault, 1'b1)
        rd(OFF_FLAGS, RESP_OKAY);
        `CK(rd_val[FLAG_TMR], 1'b1)
        rd(OFF_FLAGS, RESP_OKAY);
        `CK(rd_val[FLAG_TMR], 1'b0)
        wr(OFF_CTRL, 32'h283);
        pulse_new_cycle;
        tk(9800);
        rd(OFF_FLAGS, RESP_OKAY);
        `CK(rd_val[FLAG_TMR], 1'b0)
        $display("test precondition done");
    endtask

    // half-rate count while throttled, then the 3 hour limit at full rate
    task t_tot;
        wr(OFF_CTRL, 32'h303);
        thermal_reg_active <= 1'b1;
        current_ratio      <= 8'h80;
        pulse_new_cycle;
        tk(800);
        rd(OFF_TOT_CNT, RESP_OKAY);
        `CK((rd_val > 32'h61) && (rd_val < 32'h68), 1'b1)
        thermal_reg_active <= 1'b0;
        pulse_new_cycle;
        wait_exp;
        `CK((n > 4 * TOT_SEC_0 - 5) && (n < 4 * TOT_SEC_0 + 9), 1'b1)
        `CK(total_expire, 1'b1)
        rd(OFF_FLAGS, RESP_OKAY);
        `CK(rd_val[FLAG_TMR], 1'b1)
        $display("test total done");
    endtask

    task conclude;
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // main sequence, inputs settled at time zero
    initial
    begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        {aresetn, new_cycle, vbat_precond_ok, thermal_reg_active} = '0;
        current_ratio = 8'hff;
        charger_input_supply = 1'b1;
        temp_zone = 2'h0;
        charger_state = CHG_EOC;
        tk(2);
        aresetn <= 1'b1;
        t_regs;
        t_pin;
        t_temp;
        t_drain;
        t_pre;
        t_tot;
        conclude;
    end

    // run needs about 64k cycles; a hang is cut well after that
    initial
    begin
        #900_000;
        fails++;
        conclude;
    end
endmodule
